/* dv/bus_ctrl_model.sv */
`default_nettype none
// ****
// bus controller model
// ****
module bus_ctrl_model
  import ccs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       cmdReady,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspData,
  input  wire logic       cmdError,
  input  wire logic [7:0] pollData,
  output var  cmd_req_t   cmdReq,
  output var  logic       serialPoll,
  output var  logic       setOutputOn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp;
  logic       rspOk;
  logic       err;

  // idle bus at time zero
  initial
  begin
    cmdReq = '0;
    serialPoll = 1'b0;
    setOutputOn = 1'b0;
  end

  // request held until taken, answer caught the cycle after
  task automatic cmd(input cmd_t op, input logic [7:0] arg);
    @(posedge ref_clk);
    #1 cmdReq = '{1'b1, op, arg};
    while (cmdReady !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1 rspOk = rspValid;
    err = cmdError;
    rsp = rspData;
    cmdReq = '{1'b0, CMD_NONE, ~arg}; // no stale argument on a released bus
  endtask

  // one-cycle serial poll, byte caught once registered
  task automatic poll();
    @(posedge ref_clk);
    #1 serialPoll = 1'b1;
    @(posedge ref_clk);
    #1 serialPoll = 1'b0;
    rsp = pollData;
  endtask

  // output-on, needed after a reset command
  task automatic outOn();
    @(posedge ref_clk);
    #1 setOutputOn = 1'b1;
    @(posedge ref_clk);
    #1 setOutputOn = 1'b0;
  endtask
endmodule // bus_ctrl_model
`default_nettype wire

/* dv/ccs_asserts.sv */
`default_nettype none
// ****
// port checks of the command unit
// ****
module ccs_chk
  import ccs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire cmd_req_t   cmdReq,
  input wire logic       cmdReady,
  input wire logic       rspValid,
  input wire logic [7:0] rspData,
  input wire logic       cmdError,
  input wire logic       listenAddressed,
  input wire logic       serialPoll,
  input wire logic [7:0] pollData,
  input wire logic       continuous_arming,
  input wire logic [7:0] eventStatus,
  input wire logic [7:0] eventEnable,
  input wire logic       operSummary,
  input wire logic       msgAvailable,
  input wire logic       ovpTrip,
  input wire logic       ocpTrip,
  input wire logic [7:0] subtestFail,
  input wire logic       outputOn,
  input wire trig_set_t  outLevel,
  input wire logic       rangeAuto,
  input wire logic       protLatched,
  input wire logic       waiting_for_trigger_flag
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // accepted command decodes
  wire logic take = cmdReq.valid && cmdReady;
  wire logic locCmd = take && (cmdReq.op == CMD_RCL || cmdReq.op == CMD_SAV);
  wire logic badLoc = cmdReq.arg == 8'h00 || cmdReq.arg > 8'h63;

  rst_out_a: assert property (
    take && cmdReq.op == CMD_RST |=> !outputOn && outLevel == '0 && rangeAuto)
    else $error("reset left output wrong");
  rst_prot_a: assert property (
    take && cmdReq.op == CMD_RST && !ovpTrip && !ocpTrip |=> !protLatched)
    else $error("reset kept protection latch");
  trg_deaf_a: assert property (
    take && cmdReq.op == CMD_TRG && !listenAddressed |=> $stable(outLevel))
    else $error("trigger acted while not listener");
  trg_arm_a: assert property (
    take && cmdReq.op == CMD_TRG && listenAddressed && waiting_for_trigger_flag
    |=> waiting_for_trigger_flag == $past(continuous_arming))
    else $error("waiting flag wrong after trigger");
  loc_bad_a: assert property (locCmd && badLoc |=> cmdError)
    else $error("bad location not refused");
  loc_ok_a: assert property (locCmd && !badLoc |=> !cmdError)
    else $error("good location refused");
  sre_bit6_a: assert property (
    take && cmdReq.op == CMD_SREQ |=> rspValid && !rspData[STB_RQS])
    else $error("mask bit 6 stored");
  tst_code_a: assert property (
    take && cmdReq.op == CMD_TST |=> rspValid && rspData == $past(subtestFail))
    else $error("self test code wrong");
  poll_bits_a: assert property (
    serialPoll |=> pollData[STB_OPER] == $past(operSummary)
    && pollData[STB_MAV] == $past(msgAvailable) && pollData[1:0] == 2'h0
    && pollData[STB_ESB] == |($past(eventStatus) & $past(eventEnable)))
    else $error("poll byte layout wrong");
  wai_hold_a: assert property (
    take && cmdReq.op == CMD_WAI |=> !cmdReady ##[1:24] cmdReady)
    else $error("wait hold wrong");
endmodule // ccs_chk

bind common_command_status_unit ccs_chk ccs_chk_i (
  .ref_clk, .arst_n, .cmdReq, .cmdReady, .rspValid, .rspData, .cmdError,
  .listenAddressed, .serialPoll, .pollData, .continuous_arming, .eventStatus,
  .eventEnable, .operSummary, .msgAvailable, .ovpTrip, .ocpTrip, .subtestFail,
  .outputOn, .outLevel, .rangeAuto, .protLatched, .waiting_for_trigger_flag
);
`default_nettype wire

/* dv/tb_common_command_status_unit.sv */
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
// ****
// testbench top
// ****
module tb_common_command_status_unit
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, arst_n, cmdReady, rspValid, cmdError, listenAddressed;
  logic       serialPoll, armReq, continuous_arming, setOutputOn, trigWriteEn;
  logic       operSummary, msgAvailable, quesSummary, error_queue_nonempty;
  logic       ovpTrip, ocpTrip, outputOn, rangeAuto, protLatched, settleBusy;
  logic       waiting_for_trigger_flag;
  logic [7:0] rspData, pollData, eventStatus, eventEnable, subtestFail;
  cmd_req_t   cmdReq;
  trig_set_t  trigWrite, outLevel;
  int         n_fail, checks, cyc;

  common_command_status_unit common_command_status_unit_i (
    .ref_clk, .arst_n, .cmdReq, .cmdReady, .rspValid, .rspData, .cmdError,
    .listenAddressed, .serialPoll, .pollData, .armReq, .continuous_arming,
    .setOutputOn, .trigWrite, .trigWriteEn, .eventStatus, .eventEnable,
    .operSummary, .msgAvailable, .quesSummary, .error_queue_nonempty, .ovpTrip,
    .ocpTrip, .subtestFail, .outputOn, .outLevel, .rangeAuto, .protLatched,
    .waiting_for_trigger_flag, .settleBusy
  );
  bus_ctrl_model bus_ctrl_model_i (
    .ref_clk, .cmdReady, .rspValid, .rspData, .cmdError, .pollData, .cmdReq,
    .serialPoll, .setOutputOn
  );

  // 50 ns clock and a hang guard far above the run length
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic load(input trig_set_t v);
    trigWrite = v;
    pulse(trigWriteEn);
  endtask

  // mask, status byte and poll; poll clears only the request flag
  task automatic t_status();
    bus_ctrl_model_i.cmd(CMD_SREQ, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'h00)
    bus_ctrl_model_i.cmd(CMD_SRE, 8'hFF);
    bus_ctrl_model_i.cmd(CMD_SREQ, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'hBF)
    {operSummary, msgAvailable, quesSummary, error_queue_nonempty} = 4'hF;
    eventStatus = 8'h24;
    eventEnable = 8'h04;
    bus_ctrl_model_i.cmd(CMD_STBQ, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'hFC)
    bus_ctrl_model_i.poll();
    `CHK(bus_ctrl_model_i.rsp, 8'hFC)
    bus_ctrl_model_i.poll();
    `CHK(bus_ctrl_model_i.rsp, 8'hBC)
    bus_ctrl_model_i.cmd(CMD_STBQ, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'hFC)
    eventEnable = 8'h00;
    bus_ctrl_model_i.cmd(CMD_SRE, 8'h20);
    bus_ctrl_model_i.cmd(CMD_STBQ, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'h9C)
  endtask

  // save at the top location, refused locations, recall pair
  task automatic t_store();
    load('{16'h1234, 16'h0567, MODE_CURR});
    bus_ctrl_model_i.cmd(CMD_SAV, 8'h63);
    `CHK(bus_ctrl_model_i.err, 1'b0)
    load('{16'h0ABC, 16'h0DEF, MODE_VOLT});
    bus_ctrl_model_i.cmd(CMD_SAV, 8'h64);
    `CHK(bus_ctrl_model_i.err, 1'b1)
    bus_ctrl_model_i.cmd(CMD_RCL, 8'h00);
    `CHK(bus_ctrl_model_i.err, 1'b1)
    bus_ctrl_model_i.cmd(CMD_RCL, 8'h63);
    `CHK(outLevel, trig_set_t'('0))
    bus_ctrl_model_i.cmd(CMD_RCL, 8'h63);
    tick(2);
    `CHK(outLevel, {16'h1234, 16'h0567, MODE_CURR})
  endtask

  // deaf trigger, armed trigger, re-arm, then wait for settling
  task automatic t_trigger();
    int n;
    load('{16'h0F0F, 16'h00F0, MODE_VOLT});
    pulse(armReq);
    bus_ctrl_model_i.cmd(CMD_TRG, 8'h00);
    `CHK({outLevel.voltage, waiting_for_trigger_flag}, {16'h1234, 1'b1})
    listenAddressed = 1'b1;
    bus_ctrl_model_i.cmd(CMD_TRG, 8'h00);
    // trigger moves levels only; the mode from the recall stays
    `CHK({outLevel, waiting_for_trigger_flag}, {16'h0F0F, 16'h00F0, MODE_CURR, 1'b0})
    continuous_arming = 1'b1;
    pulse(armReq);
    bus_ctrl_model_i.cmd(CMD_TRG, 8'h00);
    `CHK(waiting_for_trigger_flag, 1'b1)
    `CHK(settleBusy, 1'b1)
    bus_ctrl_model_i.cmd(CMD_WAI, 8'h00);
    n = 0;
    while (cmdReady !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    `CHK(n inside {[1:20]}, 1'b1)
    `CHK(settleBusy, 1'b0)
  endtask

  // reset command after a protection trip with output on
  task automatic t_reset();
    pulse(ovpTrip);
    bus_ctrl_model_i.outOn();
    `CHK({outputOn, protLatched}, 2'h3)
    bus_ctrl_model_i.cmd(CMD_RST, 8'h00);
    `CHK({outputOn, protLatched, rangeAuto}, 3'h1)
    `CHK(outLevel, trig_set_t'('0))
    bus_ctrl_model_i.outOn();
    `CHK(outputOn, 1'b1)
  endtask

  // self test codes, each failing subtest keeps its bit
  task automatic t_selftest();
    foreach (subtestFail[i])
    begin
      subtestFail = 8'h01 << i;
      bus_ctrl_model_i.cmd(CMD_TST, 8'h00);
      `CHK(bus_ctrl_model_i.rsp, 8'h01 << i)
    end
    // several failures at once keep every bit
    subtestFail = 8'hA5;
    bus_ctrl_model_i.cmd(CMD_TST, 8'h00);
    `CHK(bus_ctrl_model_i.rsp, 8'hA5)
    subtestFail = 8'h00;
    bus_ctrl_model_i.cmd(CMD_TST, 8'h00);
    `CHK({bus_ctrl_model_i.rspOk, bus_ctrl_model_i.rsp}, 9'h100)
  endtask

  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {ref_clk, arst_n, listenAddressed, armReq, continuous_arming} = '0;
    {trigWriteEn, ovpTrip, ocpTrip, operSummary, msgAvailable} = '0;
    {quesSummary, error_queue_nonempty, eventStatus, eventEnable} = '0;
    subtestFail = 8'h00;
    trigWrite = '0;
    tick(20);
    arst_n = 1'b1;
    tick(1);
    `CHK({cmdReady, rangeAuto, outputOn, waiting_for_trigger_flag}, 4'hC)
    t_status();
    t_store();
    t_trigger();
    t_reset();
    t_selftest();
    results();
  end
endmodule // tb_common_command_status_unit
`default_nettype wire

/* hw/ccs_pkg.sv */
`default_nettype none
package ccs_pkg;

  // ****************************************
  // sizes and ranges
  // ****************************************
  localparam int LVL_W = 16;
  localparam int LOC_W = 7;
  localparam int MODE_W = 2;
  localparam int TST_W = 8;
  localparam logic [LOC_W-1:0] LOC_MIN = 7'h01;
  localparam logic [LOC_W-1:0] LOC_MAX = 7'h63;
  localparam int MEM_DEPTH = 128;

  // ****************************************
  // status byte bit positions
  // ****************************************
  localparam int STB_OPER = 7;
  localparam int STB_RQS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;
  localparam int STB_ERRQ = 2;
  localparam logic [7:0] SRE_WMASK = 8'hBF;
  localparam logic [7:0] STB_UNUSED = 8'h03;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [LVL_W-1:0] LVL_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [MODE_W-1:0] MODE_VOLT = 2'h0;
  localparam logic [MODE_W-1:0] MODE_CURR = 2'h1;
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W = 5;
  localparam int NUM_SUBTESTS = 8;

  // ****************************************
  // commands
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NONE  = 4'h0,
    CMD_RCL   = 4'h1,
    CMD_SAV   = 4'h2,
    CMD_RST   = 4'h3,
    CMD_SRE   = 4'h4,
    CMD_SREQ  = 4'h5,
    CMD_STBQ  = 4'h6,
    CMD_TRG   = 4'h7,
    CMD_TST   = 4'h8,
    CMD_WAI   = 4'h9,
    CMD_OTHER = 4'hA
  } cmd_t;

  typedef struct packed {
    logic [LVL_W-1:0]  voltage;
    logic [LVL_W-1:0]  current;
    logic [MODE_W-1:0] mode;
  } trig_set_t;

  typedef struct packed {
    logic             valid;
    cmd_t             op;
    logic [7:0]       arg;
  } cmd_req_t;

endpackage
`default_nettype wire

/* hw/common_command_status_unit.sv */
// Contract
// [R1] recall of location 1..99 loads stored triggers into trigger control section
// [R2] second consecutive recall moves trigger section values to the output channel
// [R3] save of location 1..99 stores present trigger values
// [R4] reset command: output off, levels zero, voltage mode
// [R5] reset command clears latched overvoltage or overcurrent
// [R6] controller must send output-on after reset to see programmed values
// [R7] reset command returns mode to voltage and range to automatic
// [R8] service request mask takes 0..255, bit 6 not writable
// [R9] status bit 6 is OR of enabled status bits
// [R10] status layout: oper, summary, event, message, questionable, error queue
// [R11] mask query returns stored mask
// [R12] status query returns byte, bit 6 summary, no clearing
// [R13] serial poll returns request flag in bit 6, then resets it
// [R14] trigger while armed applies trigger levels and clears waiting flag
// [R15] continuous arming re-arms at once after each trigger
// [R16] trigger acts only when addressed as listener
// [R17] self test returns zero on pass, nonzero code on failure
// [R18] self test runs every subtest, one code bit per failure
// [R19] wait command holds later commands until output settles
// [R20] event summary is OR of enabled standard event bits
// [R21] out of range location rejected with error, nothing changes
`default_nettype none
module common_command_status_unit
  import ccs_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire cmd_req_t                cmdReq,
  output logic                         cmdReady,
  output logic                         rspValid,
  output logic [7:0]                   rspData,
  output logic                         cmdError,
  input  wire logic                    listenAddressed,
  input  wire logic                    serialPoll,
  output logic [7:0]                   pollData,
  input  wire logic                    armReq,
  input  wire logic                    continuous_arming,
  input  wire logic                    setOutputOn,
  input  wire trig_set_t               trigWrite,
  input  wire logic                    trigWriteEn,
  input  wire logic [7:0]              eventStatus,
  input  wire logic [7:0]              eventEnable,
  input  wire logic                    operSummary,
  input  wire logic                    msgAvailable,
  input  wire logic                    quesSummary,
  input  wire logic                    error_queue_nonempty,
  input  wire logic                    ovpTrip,
  input  wire logic                    ocpTrip,
  input  wire logic [NUM_SUBTESTS-1:0] subtestFail,
  output logic                         outputOn,
  output trig_set_t                    outLevel,
  output logic                         rangeAuto,
  output logic                         protLatched,
  output logic                         waiting_for_trigger_flag,
  output logic                         settleBusy
);

  // ****************************************
  // storage instance
  // ****************************************
  logic             memWr;
  logic [LOC_W-1:0] memLoc;
  trig_set_t        memRd;
  trig_set_t        trig_ff, nxt_trig;

  trig_store trig_store_i (
    .ref_clk (ref_clk),
    .wrEn    (memWr),
    .wrLoc   (memLoc),
    .wrData  (trig_ff),
    .rdLoc   (memLoc),
    .rdData  (memRd)
  );

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RDMEM = 2'b01,
    ST_WAIT  = 2'b10
  } state_t;

  state_t                state_ff, nxt_state;
  logic                  ready_ff, nxt_ready;
  logic                  busy_ff, nxt_busy;
  trig_set_t             level_ff, nxt_level;
  logic [7:0]            mask_ff, nxt_mask;
  logic                  rqs_ff, nxt_rqs;
  logic                  prevMss_ff, nxt_prevMss;
  logic                  lastRcl_ff, nxt_lastRcl;
  logic                  wtg_ff, nxt_wtg;
  logic                  outOn_ff, nxt_outOn;
  logic                  rngAuto_ff, nxt_rngAuto;
  logic                  prot_ff, nxt_prot;
  logic [SETTLE_W-1:0]   settle_ff, nxt_settle;
  logic                  rspV_ff, nxt_rspV;
  logic [7:0]            rspD_ff, nxt_rspD;
  logic                  err_ff, nxt_err;
  logic [7:0]            poll_ff, nxt_poll;
  logic [LOC_W-1:0]      loc_ff, nxt_loc;

  // ****************************************
  // status byte assembly
  // ****************************************
  logic       esb;
  logic       mss;
  logic [7:0] stbBase;
  logic [7:0] stbMss;
  logic [7:0] stbRqs;
  logic       locOk;
  logic [LOC_W-1:0] argLoc;

  always_comb
  begin
    esb = |(eventStatus & eventEnable);                    // see [R20]
    stbBase = BYTE_ZERO;
    stbBase[STB_OPER] = operSummary;                       // see [R10]
    stbBase[STB_ESB] = esb;
    stbBase[STB_MAV] = msgAvailable;
    stbBase[STB_QUES] = quesSummary;
    stbBase[STB_ERRQ] = error_queue_nonempty;
    mss = |(stbBase & mask_ff & SRE_WMASK & ~STB_UNUSED);  // see [R9]
    stbMss = stbBase;
    stbMss[STB_RQS] = mss;                                 // see [R12]
    stbRqs = stbBase;
    stbRqs[STB_RQS] = rqs_ff;                              // see [R13]
    argLoc = cmdReq.arg[LOC_W-1:0];
    locOk = (cmdReq.arg[7] == 1'b0) && (argLoc >= LOC_MIN) && (argLoc <= LOC_MAX);
  end

  // ****************************************
  // command execution next state
  // ****************************************
  // only one command in flight; wait blocks the port until settle ends
  always_comb
  begin
    nxt_state = state_ff;
    nxt_trig = trig_ff;
    nxt_level = level_ff;
    nxt_mask = mask_ff;
    nxt_rqs = rqs_ff;
    nxt_prevMss = mss;
    nxt_lastRcl = lastRcl_ff;
    nxt_wtg = wtg_ff;
    nxt_outOn = outOn_ff;
    nxt_rngAuto = rngAuto_ff;
    nxt_prot = prot_ff | ovpTrip | ocpTrip;
    nxt_settle = (settle_ff != '0) ? settle_ff - 1'b1 : settle_ff;
    nxt_rspV = 1'b0;
    nxt_rspD = rspD_ff;
    nxt_err = 1'b0;
    nxt_poll = poll_ff;
    nxt_loc = loc_ff;
    memWr = 1'b0;
    memLoc = loc_ff;

    // request flag rises on a new summary, poll clears it; new rise wins
    if (serialPoll)
    begin
      nxt_poll = stbRqs;
      nxt_rqs = 1'b0;                                      // see [R13]
    end
    if (mss && !prevMss_ff)
    begin
      nxt_rqs = 1'b1;
    end

    if (armReq)
    begin
      nxt_wtg = 1'b1;
    end
    if (setOutputOn)
    begin
      nxt_outOn = 1'b1;                                    // see [R6]
    end
    if (trigWriteEn)
    begin
      nxt_trig = trigWrite;
    end

    unique case (state_ff)
      ST_IDLE:
      begin
        if (cmdReq.valid)
        begin
          nxt_lastRcl = (cmdReq.op == CMD_RCL) ? lastRcl_ff : 1'b0;
          unique case (cmdReq.op)
            CMD_RCL:
            begin
              if (!locOk)
              begin
                nxt_err = 1'b1;                            // see [R21]
                nxt_lastRcl = 1'b0;
              end
              else if (lastRcl_ff)
              begin
                nxt_level = trig_ff;                       // see [R2]
                nxt_settle = SETTLE_W'(SETTLE_CYC);
                nxt_lastRcl = 1'b0;
              end
              else
              begin
                nxt_loc = argLoc;
                memLoc = argLoc;                           // read launched at the take edge
                nxt_state = ST_RDMEM;                      // see [R1]
              end
            end
            CMD_SAV:
            begin
              if (locOk)
              begin
                memLoc = argLoc;
                memWr = 1'b1;                              // see [R3]
              end
              else
              begin
                nxt_err = 1'b1;                            // see [R21]
              end
            end
            CMD_RST:
            begin
              nxt_outOn = 1'b0;                            // see [R4]
              nxt_level.voltage = LVL_ZERO;
              nxt_level.current = LVL_ZERO;
              nxt_level.mode = MODE_VOLT;                  // see [R7]
              nxt_rngAuto = 1'b1;
              nxt_prot = ovpTrip | ocpTrip;                // see [R5] same-cycle trip wins
              nxt_settle = SETTLE_W'(SETTLE_CYC);
            end
            CMD_SRE:
            begin
              nxt_mask = (cmdReq.arg & SRE_WMASK) | (mask_ff & ~SRE_WMASK); // see [R8]
            end
            CMD_SREQ:
            begin
              nxt_rspV = 1'b1;
              nxt_rspD = mask_ff;                          // see [R11]
            end
            CMD_STBQ:
            begin
              nxt_rspV = 1'b1;
              nxt_rspD = stbMss;                           // see [R12]
            end
            CMD_TRG:
            begin
              if (listenAddressed && wtg_ff)               // see [R16]
              begin
                nxt_level.voltage = trig_ff.voltage;       // see [R14]
                nxt_level.current = trig_ff.current;
                nxt_settle = SETTLE_W'(SETTLE_CYC);
                nxt_wtg = continuous_arming;               // see [R15]
              end
            end
            CMD_TST:
            begin
              nxt_rspV = 1'b1;
              nxt_rspD = TST_W'(subtestFail);              // see [R17] [R18]
            end
            CMD_WAI:
            begin
              nxt_state = ST_WAIT;                         // see [R19]
            end
            default:
            begin
              nxt_lastRcl = 1'b0;
            end
          endcase
        end
      end
      ST_RDMEM:
      begin
        nxt_trig = memRd;                                  // see [R1]
        nxt_lastRcl = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_WAIT:
      begin
        if (settle_ff == '0)
        begin
          nxt_state = ST_IDLE;                             // see [R19]
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
    // ready and busy registered so the ports come straight from flops
    nxt_ready = (nxt_state == ST_IDLE);
    nxt_busy = (nxt_settle != '0);
  end

  // ****************************************
  // registers
  // ****************************************
  // reset gives power-on defaults, mask starts cleared
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b1;
      busy_ff <= 1'b0;
      trig_ff <= '0;
      level_ff <= '0;
      mask_ff <= BYTE_ZERO;
      rqs_ff <= 1'b0;
      prevMss_ff <= 1'b0;
      lastRcl_ff <= 1'b0;
      wtg_ff <= 1'b0;
      outOn_ff <= 1'b0;
      rngAuto_ff <= 1'b1;
      prot_ff <= 1'b0;
      settle_ff <= '0;
      rspV_ff <= 1'b0;
      rspD_ff <= BYTE_ZERO;
      err_ff <= 1'b0;
      poll_ff <= BYTE_ZERO;
      loc_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      busy_ff <= nxt_busy;
      trig_ff <= nxt_trig;
      level_ff <= nxt_level;
      mask_ff <= nxt_mask;
      rqs_ff <= nxt_rqs;
      prevMss_ff <= nxt_prevMss;
      lastRcl_ff <= nxt_lastRcl;
      wtg_ff <= nxt_wtg;
      outOn_ff <= nxt_outOn;
      rngAuto_ff <= nxt_rngAuto;
      prot_ff <= nxt_prot;
      settle_ff <= nxt_settle;
      rspV_ff <= nxt_rspV;
      rspD_ff <= nxt_rspD;
      err_ff <= nxt_err;
      poll_ff <= nxt_poll;
      loc_ff <= nxt_loc;
    end
  end

  // outputs straight from flops
  assign rspValid = rspV_ff;
  assign rspData = rspD_ff;
  assign cmdError = err_ff;
  assign pollData = poll_ff;
  assign outputOn = outOn_ff;
  assign outLevel = level_ff;
  assign rangeAuto = rngAuto_ff;
  assign protLatched = prot_ff;
  assign waiting_for_trigger_flag = wtg_ff;
  assign settleBusy = busy_ff;
  assign cmdReady = ready_ff;

endmodule // common_command_status_unit
`default_nettype wire

/* hw/trig_store.sv */
`default_nettype none
module trig_store
  import ccs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             wrEn,
  input  wire logic [LOC_W-1:0] wrLoc,
  input  wire trig_set_t        wrData,
  input  wire logic [LOC_W-1:0] rdLoc,
  output var  trig_set_t        rdData
);

  // ****************************************
  // location store, no reset: models flash
  // ****************************************
  trig_set_t mem [MEM_DEPTH];

  // registered read, one cycle latency
  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrLoc] <= wrData;
    end
    rdData <= mem[rdLoc];
  end

endmodule // trig_store
`default_nettype wire
